// File: tdse_tx_chan.sv
// TX DMA channel state entry engine with APB access to control memory
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module tdse_tx_chan #(
  parameter logic [15:0] RING_SIZE_DEF = tdse_pkg::RING_SIZE_RST
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [tdse_pkg::PADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  input wire logic sched_valid_i,
  input wire logic [tdse_pkg::CH_W-1:0] sched_chan_i,
  output logic sched_ready_o,
  output logic req_valid_o,
  output tdse_pkg::tdse_mreq_t req_o,
  input wire logic resp_valid_i,
  input wire tdse_pkg::tdse_mresp_t resp_i,
  output logic cmpl_valid_o,
  output tdse_pkg::tdse_cmpl_t cmpl_o,
  output logic eop_valid_o,
  output tdse_pkg::tdse_eop_t eop_o
);
  import tdse_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_RD,
    ST_DECIDE,
    ST_RING,
    ST_DESC,
    ST_DATA,
    ST_EOP,
    ST_CLR,
    ST_WB
  } tdse_st_t;

  function automatic logic [MEM_AW-1:0] word_addr(
    input logic [CH_W-1:0] ch,
    input logic [WSEL_W-1:0] wd
  );
    return {ch, wd};
  endfunction : word_addr

  // Index past the ring size folds back to the first entry
  function automatic logic [7:0] ring_next(
    input logic [7:0] idx,
    input logic [15:0] size
  );
    logic [15:0] n;
    n = {8'h00, idx} + 16'h0001;
    return (n > size) ? 8'h00 : n[7:0];
  endfunction : ring_next

  // Entry that was taken last, undoing one step of ring_next
  function automatic logic [7:0] ring_prev(
    input logic [7:0] idx,
    input logic [15:0] size
  );
    logic [7:0] top;
    top = (size > 16'h00ff) ? 8'hff : size[7:0];
    return (idx == 8'h00) ? top : idx - 8'h01;
  endfunction : ring_prev

  function automatic tdse_mreq_t mk_req(
    input tdse_mkind_t kind,
    input logic [31:0] addr,
    input logic [15:0] len
  );
    tdse_mreq_t r;
    r.kind = kind;
    r.addr = addr;
    r.len = len;
    return r;
  endfunction : mk_req

  tdse_st_t st_ff;
  logic [CH_W-1:0] chan_ff;
  logic [WSEL_W-1:0] rd_cnt_ff;
  logic [WSEL_W-1:0] wb_idx_ff;
  logic [4:0][31:0] wd_ff;
  logic [31:0] buf_ff;
  logic first_ff;
  logic req_valid_ff;
  tdse_mreq_t req_ff;
  logic cmpl_valid_ff;
  tdse_cmpl_t cmpl_ff;
  logic eop_valid_ff;
  tdse_eop_t eop_ff;
  logic apb_ack_ff;
  logic [31:0] ctrl_ff;
  logic [15:0] ring_size_ff;

  // Field views of the entry being worked on
  wire logic [31:0] w0 = wd_ff[WD_CTL];
  wire logic [31:0] w3 = wd_ff[WD_ON];
  wire logic [1:0] pkt_type = w0[TYPE_HI:TYPE_LO];
  wire logic [15:0] cnt = w0[CNT_HI:CNT_LO];
  wire logic [7:0] ring_idx = w3[IDX_HI:IDX_LO];
  wire logic [15:0] xfer_len = (cnt > CELL_BYTES) ? CELL_BYTES : cnt;
  wire logic is_aal5 = (pkt_type == TY_AAL5);
  wire logic pti_mark = (pkt_type == TY_TRANSP_EOP);
  wire logic [31:0] ring_addr_prev =
    {w3[BASE_HI:BASE_LO], ring_prev(ring_idx, ring_size_ff), 2'b00};
  wire logic [31:0] ring_addr_cur =
    {w3[BASE_HI:BASE_LO], ring_idx, 2'b00};
  wire logic [31:0] ring_buf = {resp_i.words[0][PTR_HI:0], 2'b00};
  wire logic [31:0] d0 = resp_i.words[0];
  wire logic [31:0] d1 = resp_i.words[1];
  wire logic [31:0] data_start =
    buf_ff + DESC_BYTES + {24'h000000, d0[OFF_HI:OFF_LO]};

  // APB decode
  wire logic apb_mem_sel = psel_i & paddr_i[MEM_SEL_BIT];
  wire logic apb_acc = psel_i & penable_i;
  wire logic apb_mem_go = apb_mem_sel & penable_i & ~apb_ack_ff &
                          (st_ff == ST_IDLE);
  wire logic [MEM_SEL_BIT-1:0] reg_off = paddr_i[MEM_SEL_BIT-1:0];
  wire logic hit_ctrl = (reg_off == ADR_CTRL);
  wire logic hit_size = (reg_off == ADR_RING_SIZE);
  wire logic hit_stat = (reg_off == ADR_STATUS);
  wire logic reg_hit = hit_ctrl | hit_size | hit_stat;
  wire logic reg_wr = apb_acc & ~apb_mem_sel & pwrite_i;
  wire logic tx_en = ctrl_ff[B_TX_EN];
  wire logic [31:0] status_word = {18'h00000, st_ff, chan_ff};
  wire logic [31:0] reg_rdata = hit_ctrl ? ctrl_ff :
                                hit_size ? {16'h0000, ring_size_ff} :
                                hit_stat ? status_word : 32'h0000_0000;

  // Memory port; software only gets it while the engine rests
  wire logic eng_we = (st_ff == ST_WB);
  wire logic [WSEL_W-1:0] eng_wd = eng_we ? wb_idx_ff : rd_cnt_ff;
  // A write lands only on the edge that completes the transfer, so a
  // master that drops the access early leaves the entry untouched
  wire logic apb_mem_wr = apb_mem_sel & apb_acc & apb_ack_ff & pwrite_i;
  wire logic apb_port = apb_mem_go | apb_mem_wr;
  wire logic mem_we = apb_port ? apb_mem_wr : eng_we;
  wire logic [MEM_AW-1:0] mem_addr = apb_port ? paddr_i[MEM_AW+1:2] :
                                     word_addr(chan_ff, eng_wd);
  wire logic [31:0] mem_wdata = apb_port ? pwdata_i : wd_ff[wb_idx_ff];
  logic [31:0] mem_rdata;

  tdse_ctl_mem #(
    .AW(MEM_AW),
    .DW(32)
  ) u_mem (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .we_i(mem_we),
    .addr_i(mem_addr),
    .wdata_i(mem_wdata),
    .rdata_o(mem_rdata)
  );

  // Scheduling waits on the enable bit software sets after setup
  assign sched_ready_o = (st_ff == ST_IDLE) & ~apb_mem_sel & tx_en;
  wire logic sched_fire = sched_valid_i & sched_ready_o;

  assign pready_o = ~apb_mem_sel | apb_ack_ff;
  assign prdata_o = apb_mem_sel ? mem_rdata : reg_rdata;
  assign pslverr_o = apb_acc & ~apb_mem_sel & ~reg_hit;
  assign req_valid_o = req_valid_ff;
  assign req_o = req_ff;
  assign cmpl_valid_o = cmpl_valid_ff;
  assign cmpl_o = cmpl_ff;
  assign eop_valid_o = eop_valid_ff;
  assign eop_o = eop_ff;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      apb_ack_ff <= 1'b0;
      ctrl_ff <= '0;
      ring_size_ff <= RING_SIZE_DEF;
    end else begin
      apb_ack_ff <= apb_mem_go;
      if (reg_wr & hit_ctrl) begin
        ctrl_ff <= pwdata_i;
      end
      if (reg_wr & hit_size) begin
        ring_size_ff <= pwdata_i[15:0];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_ff <= ST_IDLE;
      chan_ff <= '0;
      rd_cnt_ff <= '0;
      wb_idx_ff <= '0;
      wd_ff <= '0;
      buf_ff <= '0;
      first_ff <= 1'b0;
      req_valid_ff <= 1'b0;
      req_ff <= '0;
      cmpl_valid_ff <= 1'b0;
      cmpl_ff <= '0;
      eop_valid_ff <= 1'b0;
      eop_ff <= '0;
    end else begin
      cmpl_valid_ff <= 1'b0;
      eop_valid_ff <= 1'b0;
      if (resp_valid_i) begin
        req_valid_ff <= 1'b0;
      end
      case (st_ff)
        ST_IDLE: begin
          // A zero entry is consumed without leaving idle
          if (sched_fire && sched_chan_i != '0) begin
            chan_ff <= sched_chan_i;
            rd_cnt_ff <= '0;
            st_ff <= ST_RD;
          end
        end
        ST_RD: begin
          rd_cnt_ff <= rd_cnt_ff + 3'h1;
          if (rd_cnt_ff != '0) begin
            wd_ff[rd_cnt_ff - 3'h1] <= mem_rdata;
          end
          if (rd_cnt_ff == NWORDS) begin
            st_ff <= ST_DECIDE;
          end
        end
        ST_DECIDE: begin
          if (!w3[B_ON]) begin
            st_ff <= ST_IDLE;
          end else if (!w0[B_ACT]) begin
            req_valid_ff <= 1'b1;
            req_ff <= mk_req(MK_RING_RD, ring_addr_cur, 16'h0004);
            st_ff <= ST_RING;
          end else if (w0[B_ABORT]) begin
            st_ff <= ST_EOP;
          end else if (cnt == 16'h0000) begin
            // Earlier chain step found the next buffer not ready
            buf_ff <= wd_ff[WD_NXT];
            first_ff <= 1'b0;
            req_valid_ff <= 1'b1;
            req_ff <= mk_req(MK_DESC_RD, wd_ff[WD_NXT], DESC_BYTES[15:0]);
            st_ff <= ST_DESC;
          end else begin
            req_valid_ff <= 1'b1;
            req_ff <= mk_req(MK_DATA_RD, wd_ff[WD_CUR], xfer_len);
            st_ff <= ST_DATA;
          end
        end
        ST_RING: begin
          if (resp_valid_i) begin
            if (!resp_i.words[0][B_OWN]) begin
              st_ff <= ST_IDLE;
            end else begin
              buf_ff <= ring_buf;
              wd_ff[WD_ON][IDX_HI:IDX_LO] <=
                ring_next(ring_idx, ring_size_ff);
              first_ff <= 1'b1;
              req_valid_ff <= 1'b1;
              req_ff <= mk_req(MK_DESC_RD, ring_buf, DESC_BYTES[15:0]);
              st_ff <= ST_DESC;
            end
          end
        end
        ST_DESC: begin
          if (resp_valid_i) begin
            wb_idx_ff <= '0;
            if (!d0[B_ACT]) begin
              // Not ready: a new packet keeps its ring slot untouched
              st_ff <= first_ff ? ST_IDLE : ST_WB;
            end else begin
              // Ready bit lands in the active position; first flag ignored
              wd_ff[WD_CTL] <= d0;
              wd_ff[WD_CUR] <= data_start;
              if (first_ff) begin
                wd_ff[WD_HDR] <= resp_i.words[2];
              end
              wd_ff[WD_NXT] <= d1 << PTR_SHIFT;
              st_ff <= d0[B_ABORT] ? ST_EOP : ST_WB;
            end
          end
        end
        ST_DATA: begin
          if (resp_valid_i) begin
            wd_ff[WD_CUR] <= wd_ff[WD_CUR] + {16'h0000, xfer_len};
            wd_ff[WD_CTL][CNT_HI:CNT_LO] <= cnt - xfer_len;
            wb_idx_ff <= '0;
            if (cnt == xfer_len) begin
              cmpl_valid_ff <= 1'b1;
              cmpl_ff <= '{chan_ff, w0[B_RSEL], 1'b0, buf_ff};
              if (w0[B_LAST]) begin
                st_ff <= ST_EOP;
              end else begin
                buf_ff <= wd_ff[WD_NXT];
                first_ff <= 1'b0;
                req_valid_ff <= 1'b1;
                req_ff <= mk_req(MK_DESC_RD, wd_ff[WD_NXT],
                                 DESC_BYTES[15:0]);
                st_ff <= ST_DESC;
              end
            end else begin
              st_ff <= ST_WB;
            end
          end
        end
        ST_EOP: begin
          // Type 11 falls to the transparent path with PTI kept
          eop_valid_ff <= 1'b1;
          eop_ff.chan <= chan_ff;
          eop_ff.aal5 <= is_aal5;
          eop_ff.pti_mark <= pti_mark;
          eop_ff.len_zero <= w0[B_ABORT] & is_aal5;
          eop_ff.pad48 <= 1'b1;
          if (w0[B_ABORT]) begin
            cmpl_valid_ff <= 1'b1;
            cmpl_ff <= '{chan_ff, w0[B_RSEL], 1'b1, buf_ff};
          end
          wd_ff[WD_CTL][B_ACT] <= 1'b0;
          req_valid_ff <= 1'b1;
          req_ff <= mk_req(MK_RING_CLR, ring_addr_prev, 16'h0004);
          st_ff <= ST_CLR;
        end
        ST_CLR: begin
          if (resp_valid_i) begin
            wb_idx_ff <= '0;
            st_ff <= ST_WB;
          end
        end
        ST_WB: begin
          wb_idx_ff <= wb_idx_ff + 3'h1;
          if (wb_idx_ff == NWORDS - 3'h1) begin
            st_ff <= ST_IDLE;
          end
        end
        default: begin
          st_ff <= ST_IDLE;
        end
      endcase
    end
  end
endmodule : tdse_tx_chan
`default_nettype wire

// File: tdse_pkg.sv
// Constants, field layouts and carrier types for the TX channel entry block
// Contract
// - Copy descriptor control word unchanged into entry
// - Active flag held during packet, cleared after
// - First-buffer flag never checked by hardware
// - Every packet ends on a last-buffer flag (code: an abort ends the packet without one)
// - Abort starts end-of-packet processing at once
// - Abort with AAL5 forces trailer length zero
// - Decode two-bit packet type field
// - AAL5 gets CRC, pad, control and length
// - Transparent types only pad to 48 bytes
// - Type 00 marks end-of-packet in PTI
// - Type 10 leaves last cell PTI untouched
// - Ring-select bit picks completion ring
// - Offset added to payload start address
// - Count tracks remaining bytes, zero ends packet (code: zero ends the buffer; packet ends on last-buffer flag)
// - Data address starts at buffer plus 16
// - Cell header copied from first buffer only
// - Channel serviced only while on bit set
// - Ring index increments, wraps past ring size
// - Ring address is base, index, two zeros
// - Zero scheduler entry skipped immediately
// - Clear whole ring entry after packet
// - Next-buffer address is pointer shifted two
package tdse_pkg;
  localparam int CH_W = 10;
  localparam int WSEL_W = 3;
  localparam int MEM_AW = CH_W + WSEL_W;
  localparam int PADDR_W = MEM_AW + 3;
  localparam int MEM_SEL_BIT = MEM_AW + 2;

  // Entry word numbers kept in control memory
  localparam logic [WSEL_W-1:0] WD_CTL = 3'h0;
  localparam logic [WSEL_W-1:0] WD_CUR = 3'h1;
  localparam logic [WSEL_W-1:0] WD_HDR = 3'h2;
  localparam logic [WSEL_W-1:0] WD_ON = 3'h3;
  localparam logic [WSEL_W-1:0] WD_NXT = 3'h4;
  localparam logic [WSEL_W-1:0] NWORDS = 3'h5;

  // Word 0 layout
  localparam int B_ACT = 31;
  localparam int B_FIRST = 30;
  localparam int B_LAST = 29;
  localparam int B_ABORT = 28;
  localparam int TYPE_HI = 27;
  localparam int TYPE_LO = 26;
  localparam int B_RSEL = 25;
  localparam int OFF_HI = 23;
  localparam int OFF_LO = 16;
  localparam int CNT_HI = 15;
  localparam int CNT_LO = 0;

  // Word 3 layout and ring entry layout
  localparam int B_ON = 31;
  localparam int BASE_HI = 29;
  localparam int BASE_LO = 8;
  localparam int IDX_HI = 7;
  localparam int IDX_LO = 0;
  localparam int B_OWN = 31;
  localparam int PTR_HI = 29;

  localparam logic [1:0] TY_TRANSP_EOP = 2'h0;
  localparam logic [1:0] TY_AAL5 = 2'h1;
  localparam logic [1:0] TY_TRANSP_RAW = 2'h2;

  localparam logic [31:0] DESC_BYTES = 32'h0000_0010;
  localparam logic [15:0] CELL_BYTES = 16'h0030;
  localparam int PTR_SHIFT = 2;

  // Register offsets within the APB window
  localparam logic [MEM_SEL_BIT-1:0] ADR_CTRL = 15'h0000;
  localparam logic [MEM_SEL_BIT-1:0] ADR_RING_SIZE = 15'h0004;
  localparam logic [MEM_SEL_BIT-1:0] ADR_STATUS = 15'h0008;
  localparam int B_TX_EN = 0;
  localparam logic [15:0] RING_SIZE_RST = 16'h00ff;

  typedef enum logic [1:0] {
    MK_RING_RD,
    MK_DESC_RD,
    MK_DATA_RD,
    MK_RING_CLR
  } tdse_mkind_t;

  typedef struct packed {
    tdse_mkind_t kind;
    logic [31:0] addr;
    logic [15:0] len;
  } tdse_mreq_t;

  typedef struct packed {
    logic [3:0][31:0] words;
  } tdse_mresp_t;

  typedef struct packed {
    logic [CH_W-1:0] chan;
    logic intr_ring;
    logic abort;
    logic [31:0] buf_addr;
  } tdse_cmpl_t;

  typedef struct packed {
    logic [CH_W-1:0] chan;
    logic aal5;
    logic pti_mark;
    logic len_zero;
    logic pad48;
  } tdse_eop_t;
endpackage : tdse_pkg

// File: tdse_ctl_mem.sv
// Control memory holding the per-channel TX entry words
`timescale 1ns/1ps
`default_nettype none
module tdse_ctl_mem #(
  parameter int AW = 13,
  parameter int DW = 32
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem_ff [2**AW];
  logic [DW-1:0] rdata_ff;

  always_ff @(posedge ref_clk_i) begin
    if (we_i) begin
      mem_ff[addr_i] <= wdata_i;
    end
  end

  // Read data is registered; it follows the address one cycle later
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= mem_ff[addr_i];
    end
  end

  assign rdata_o = rdata_ff;
endmodule : tdse_ctl_mem
`default_nettype wire

// File: tdse_tx_chan_checker.sv
// Port assertions for the TX channel entry engine
`timescale 1ns/1ps
`default_nettype none
module tdse_tx_chan_checker (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic req_valid_o,
  input wire tdse_pkg::tdse_mreq_t req_o,
  input wire logic resp_valid_i,
  input wire logic cmpl_valid_o,
  input wire logic eop_valid_o,
  input wire tdse_pkg::tdse_eop_t eop_o
);
  import tdse_pkg::*;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  wire logic ring_rq = req_valid_o &&
                       req_o.kind inside {MK_RING_RD, MK_RING_CLR};
  wire logic data_rq = req_valid_o && req_o.kind == MK_DATA_RD;
  wire logic desc_rq = req_valid_o && req_o.kind == MK_DESC_RD;
  wire logic clr_rq = req_valid_o && req_o.kind == MK_RING_CLR;
  a_ring_word: assert property (ring_rq |-> req_o.addr[1:0] == 2'h0)
    else $error("ring access not word aligned");
  a_desc_shift: assert property (desc_rq |-> req_o.addr[1:0] == 2'h0)
    else $error("descriptor address not shifted");
  a_data_cell: assert property (data_rq |->
    req_o.len != 16'h0 && req_o.len <= CELL_BYTES)
    else $error("payload fetch length out of range");
  a_req_hold: assert property (req_valid_o && !resp_valid_i |=>
    req_valid_o && $stable(req_o))
    else $error("request changed before answer");
  a_len_zero: assert property (eop_valid_o && eop_o.len_zero |->
    eop_o.aal5)
    else $error("length zeroed on non AAL5 packet");
  a_type_excl: assert property (eop_valid_o |->
    !(eop_o.aal5 && eop_o.pti_mark))
    else $error("AAL5 packet marked in PTI");
  a_pad_cell: assert property (eop_valid_o |-> eop_o.pad48)
    else $error("last cell not padded");
  a_eop_clear: assert property (eop_valid_o |-> ##[0:40] clr_rq)
    else $error("ring entry not cleared after packet");
  a_cmpl_once: assert property (cmpl_valid_o |=> !cmpl_valid_o)
    else $error("completion posted twice");
  c_aal5: cover property (eop_valid_o && eop_o.aal5);
  c_abort: cover property (eop_valid_o && eop_o.len_zero);
  c_clear: cover property (clr_rq && resp_valid_i);
endmodule : tdse_tx_chan_checker
bind tdse_tx_chan tdse_tx_chan_checker chk_u (.*);
`default_nettype wire

// File: tdse_host_model.sv
// Host memory model answering fetch and clear requests
`timescale 1ns/1ps
`default_nettype none
module tdse_host_model (
  input wire logic ref_clk_i,
  input wire logic req_valid_i,
  input wire tdse_pkg::tdse_mreq_t req_i,
  output logic resp_valid_o,
  output tdse_pkg::tdse_mresp_t resp_o
);
  import tdse_pkg::*;
  logic [31:0] mem [logic [31:0]];
  int lat = 0;
  int cnt = 0;
  initial resp_valid_o = 1'b0;
  initial resp_o = '0;
  function automatic logic [31:0] peek(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : 32'h0;
  endfunction : peek
  // Words churn while idle so stale data never looks valid
  always @(posedge ref_clk_i) begin
    resp_valid_o <= 1'b0;
    resp_o <= ~resp_o;
    if (req_valid_i && !resp_valid_o) begin
      cnt <= cnt + 1;
      if (cnt >= lat) begin
        cnt <= 0;
        resp_valid_o <= 1'b1;
        for (int k = 0; k < 4; k++) begin
          resp_o.words[k] <= peek(req_i.addr + 32'(4 * k));
        end
        if (req_i.kind == MK_RING_CLR) begin
          mem[req_i.addr] = 32'h0;
        end
      end
    end
  end
endmodule : tdse_host_model
`default_nettype wire

// File: tdse_tx_chan_tb.sv
// Self-checking bench for the TX channel entry engine
`timescale 1ns/1ps
`default_nettype none
module tdse_tx_chan_tb;
  import tdse_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [PADDR_W-1:0] paddr = '0;
  logic [31:0] pwd = '0, prd, clr_a;
  logic prdy, perr, sv = 1'b0, srdy, rqv, rsv, cv, ev;
  logic [CH_W-1:0] sch = '0;
  tdse_mreq_t rq, d_q;
  tdse_mresp_t rs;
  tdse_cmpl_t cm, c_q;
  tdse_eop_t eo, e_q;
  int n_fail = 0, total_checks = 0, n_eop = 0, n_req = 0;
  always #2.5 clk = ~clk;
  tdse_tx_chan dut_u (.ref_clk_i(clk), .rst_i(rst), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd),
    .pready_o(prdy), .prdata_o(prd), .pslverr_o(perr),
    .sched_valid_i(sv), .sched_chan_i(sch), .sched_ready_o(srdy),
    .req_valid_o(rqv), .req_o(rq), .resp_valid_i(rsv), .resp_i(rs),
    .cmpl_valid_o(cv), .cmpl_o(cm), .eop_valid_o(ev), .eop_o(eo));
  tdse_host_model host_u (.ref_clk_i(clk), .req_valid_i(rqv),
    .req_i(rq), .resp_valid_o(rsv), .resp_o(rs));
  always @(posedge clk) begin
    if (ev === 1'b1) begin
      e_q <= eo;
      n_eop <= n_eop + 1;
    end
    if (cv === 1'b1) c_q <= cm;
    if (rqv === 1'b1 && rsv === 1'b1) begin
      n_req <= n_req + 1;
      if (rq.kind == MK_DATA_RD) d_q <= rq;
      if (rq.kind == MK_RING_CLR) clr_a <= rq.addr;
    end
  end
  task wrap_up;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task tmo(input int k, input int lim);
    if (k >= lim) begin
      n_fail++;
      wrap_up();
    end
  endtask : tmo
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d,
           output logic [31:0] q, output logic e);
    int k;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (k = 0; k < 300; k++) begin
      @(posedge clk);
      if (prdy === 1'b1) break;
    end
    tmo(k, 300);
    q = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task rd(input logic [15:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask : rd
  function automatic logic [15:0] ma(input int w);
    return 16'h8020 + 16'(w * 4);
  endfunction : ma
  task wait_rdy;
    int k;
    for (k = 0; k < 3000; k++) begin
      @(posedge clk);
      if (srdy === 1'b1) break;
    end
    tmo(k, 3000);
  endtask : wait_rdy
  task t_regs;
    logic [31:0] q;
    logic e;
    rd(ADR_CTRL, q);
    chk(q, 32'h0);
    rd(ADR_RING_SIZE, q);
    chk(q, 32'h0000_00ff);
    wr(ADR_RING_SIZE, 32'h1);
    rd(ADR_RING_SIZE, q);
    chk(q, 32'h1);
    apb(1'b0, 16'h0040, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    // Channel set up before enable, ring base on a 1024-byte boundary
    wr(ma(0), 32'h0);
    wr(ma(3), 32'h8000_0400);
    wr(ADR_CTRL, 32'h1);
  endtask : t_regs
  // Five packets: all type codes, one AAL5 abort, latency rising
  task t_pkts;
    logic [1:0] ty;
    logic ab;
    logic [31:0] bf, ra, d0, q;
    int k, w;
    for (int i = 0; i < 5; i++) begin
      ty = (i == 4) ? 2'h1 : 2'(i);
      ab = (i == 4);
      ra = 32'h1000 + 32'((i % 2) * 4);
      bf = 32'h2000 + 32'(i * 256);
      d0 = {1'b1, i != 1, 1'b1, ab, ty, i[0], 1'b0, 8'h04, 16'h0010};
      host_u.lat = i;
      host_u.mem[ra] = {2'h2, bf[31:2]};
      host_u.mem[bf] = d0;
      host_u.mem[bf + 32'h4] = 32'h0;
      host_u.mem[bf + 32'h8] = 32'h1234_5670 + 32'(i);
      k = n_eop;
      sv <= 1'b1;
      sch <= 10'h1;
      for (w = 0; w < 3000 && n_eop == k; w++) @(posedge clk);
      tmo(w, 3000);
      sv <= 1'b0;
      wait_rdy();
      chk({e_q.aal5, e_q.pti_mark, e_q.len_zero, e_q.pad48},
          {ty == 2'h1, ty == 2'h0, ab, 1'b1});
      chk({c_q.intr_ring, c_q.abort}, {i[0], ab});
      chk({e_q.chan, c_q.chan}, 20'h00401);
      chk(c_q.buf_addr, bf);
      if (!ab) chk(d_q.addr, bf + 32'h14);
      if (!ab) chk(d_q.len, 16'h0010);
      chk(clr_a, ra);
      rd(ma(0), q);
      chk(q & 32'hfdff_ffff, {1'b0, d0[30:16], ab ? 16'h10 : 16'h0}
          & 32'hfdff_ffff);
      rd(ma(1), q);
      chk(q, bf + (ab ? 32'h14 : 32'h24));
      rd(ma(2), q);
      chk(q, 32'h1234_5670 + 32'(i));
      rd(ma(3), q);
      chk(q, 32'h8000_0400 + 32'((i + 1) % 2));
    end
  endtask : t_pkts
  // Two chained AAL5 buffers; the first spans more than one cell
  task t_chain;
    logic [31:0] q, w0b;
    int nr, k, w;
    w0b = {4'ha, 2'h1, 2'h2, 8'h00, 16'h0008};
    nr = n_req;
    host_u.lat = 1;
    host_u.mem[32'h1004] = 32'h8000_0c00;
    host_u.mem[32'h3000] = {4'hc, 2'h1, 2'h0, 8'h00, 16'h0040};
    host_u.mem[32'h3004] = 32'h0000_0c40;
    host_u.mem[32'h3008] = 32'h0abc_0010;
    host_u.mem[32'h3100] = w0b;
    host_u.mem[32'h3104] = 32'h0;
    host_u.mem[32'h3108] = 32'h0fff_fff0;
    k = n_eop;
    sv <= 1'b1;
    sch <= 10'h1;
    for (w = 0; w < 3000 && n_eop == k; w++) @(posedge clk);
    tmo(w, 3000);
    sv <= 1'b0;
    wait_rdy();
    chk(n_req - nr, 32'h7);
    chk({e_q.aal5, e_q.pti_mark, e_q.len_zero, e_q.pad48}, 4'h9);
    chk({c_q.intr_ring, c_q.abort}, 2'h2);
    chk(c_q.buf_addr, 32'h0000_3100);
    chk(d_q.addr, 32'h0000_3110);
    chk(d_q.len, 16'h0008);
    chk(clr_a, 32'h0000_1004);
    rd(ma(0), q);
    chk(q, {1'b0, w0b[30:16], 16'h0000});
    rd(ma(1), q);
    chk(q, 32'h0000_3118);
    rd(ma(2), q);
    chk(q, 32'h0abc_0010);
    rd(ma(3), q);
    chk(q, 32'h8000_0400);
  endtask : t_chain
  task t_skip;
    int nr;
    nr = n_req;
    sv <= 1'b1;
    sch <= 10'h0;
    wait_rdy();
    sv <= 1'b0;
    repeat (20) @(posedge clk);
    chk(n_req, nr);
  endtask : t_skip
  task t_off;
    int nr;
    wr(ma(3), 32'h0000_0401);
    nr = n_req;
    sv <= 1'b1;
    sch <= 10'h1;
    repeat (30) @(posedge clk);
    sv <= 1'b0;
    chk(n_req, nr);
  endtask : t_off
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_skip();
    t_pkts();
    t_chain();
    t_off();
    wrap_up();
  end
endmodule : tdse_tx_chan_tb
`default_nettype wire
